// ---- slhr_stop_exit.sv ----
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "slhr_defines.svh"
module slhr_stop_exit
    import slhr_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        aclken,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Core events, same clock
    input  wire logic        stop_instr,
    input  wire logic        slow_divided_clock_tick,
    // Asynchronous pins and monitor
    input  wire logic        ext_reset_pin,
    input  wire logic        irq_pin_n,
    input  wire logic        nonmaskable_interrupt_pin,
    input  wire logic        key_wake_j,
    input  wire logic        key_wake_h,
    input  wire logic        can_wake,
    input  wire logic        clock_monitor_ok,
    // Clock control outputs
    output logic             stop_active,
    output logic             pseudo_stop_active,
    output logic             limp_home_mode,
    output logic             clock_monitor_force,
    output logic             clock_monitor_enable,
    output logic             bus_clock_pll_select,
    output logic             module_clock_select,
    output logic             vco_restart,
    output logic             pll_ramp_request,
    output logic             clock_monitor_reset,
    output logic             limp_home_irq
);
    slhr_state_t state_r;
    logic [31:0] ctrl_r;
    logic [1:0]  clksel_r;
    logic [1:0]  saved_sel_r;
    logic        saved_auto_r;
    logic        active_r;
    logic        change_r;
    logic        pstop_r;
    logic        cmfail_r;
    logic [5:0]  sync1_r;
    logic [5:0]  sync2_r;
    logic        cnt_clear;
    logic        cnt_tick;
    logic        mid_hit;
    slhr_cnt_t   count;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_go;
    logic        change_clr;
    logic        wake;
    logic        mon_ok;

    function automatic logic [31:0] slhr_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[i*8 +: 8] = dat[i*8 +: 8];
        return res;
    endfunction : slhr_merge

    // Two-stage synchronisers for pins and the monitor
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 6'h01;
            sync2_r <= 6'h01;
        end
        else if (aclken)
        begin
            sync1_r <= {clock_monitor_ok, can_wake, key_wake_h | key_wake_j,
                        nonmaskable_interrupt_pin, ext_reset_pin, irq_pin_n};
            sync2_r <= sync1_r;
        end
    end

    assign wake   = ~sync2_r[0] | sync2_r[1] | sync2_r[2] | sync2_r[3] | sync2_r[4];
    assign mon_ok = sync2_r[5];

    // AXI write channel capture, address and data in either order
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SLHR_RESP_OKAY;
        end
        else if (aclken)
        begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r == `SLHR_ADDR_CTRL || awaddr_r == `SLHR_ADDR_STATUS ||
                                 awaddr_r == `SLHR_ADDR_CLKSEL) ? `SLHR_RESP_OKAY : `SLHR_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SLHR_RESP_OKAY;
        end
        else if (aclken)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `SLHR_RESP_OKAY;
                case (s_axi_araddr)
                    `SLHR_ADDR_CTRL:   s_axi_rdata <= ctrl_r;
                    `SLHR_ADDR_STATUS: s_axi_rdata <= {27'h0, cmfail_r, pstop_r,
                                                       state_r != SLHR_RUN, change_r, active_r};
                    `SLHR_ADDR_CLKSEL: s_axi_rdata <= {30'h0, clksel_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `SLHR_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_r <= `SLHR_CTRL_RESET;
        else if (aclken && wr_go && awaddr_r == `SLHR_ADDR_CTRL)
            ctrl_r <= slhr_merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_007F;
    end

    assign change_clr = wr_go && awaddr_r == `SLHR_ADDR_STATUS && wstrb_r[0] && wdata_r[`SLHR_ST_CHANGE];

    // Stop / limp-home sequencer
    assign cnt_tick  = slow_divided_clock_tick;
    assign cnt_clear = (state_r == SLHR_STOP);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r      <= SLHR_RUN;
            active_r     <= 1'b0;
            pstop_r      <= 1'b0;
            cmfail_r     <= 1'b0;
            saved_sel_r  <= 2'b00;
            saved_auto_r <= 1'b0;
            clksel_r     <= 2'b00;
            vco_restart  <= 1'b0;
            pll_ramp_request <= 1'b0;
            clock_monitor_reset <= 1'b0;
        end
        else if (aclken)
        begin
            vco_restart         <= 1'b0;
            pll_ramp_request    <= 1'b0;
            clock_monitor_reset <= 1'b0;
            if (wr_go && awaddr_r == `SLHR_ADDR_CLKSEL && wstrb_r[0])
                clksel_r <= wdata_r[1:0];
            case (state_r)
                SLHR_RUN:
                begin
                    if (stop_instr)
                    begin
                        pstop_r      <= ctrl_r[`SLHR_CTRL_PSEUDO_STOP_SELECT];
                        if (!ctrl_r[`SLHR_CTRL_NOLH])
                            state_r <= SLHR_STOP;
                        else if (ctrl_r[`SLHR_CTRL_CME] | ctrl_r[`SLHR_CTRL_FORCED_CLOCK_MONITOR_ENABLE])
                        begin
                            cmfail_r            <= 1'b1;
                            clock_monitor_reset <= 1'b1;
                            pstop_r             <= 1'b0;
                        end
                        else
                            state_r <= SLHR_STOP;
                        saved_sel_r  <= clksel_r;
                        saved_auto_r <= ctrl_r[`SLHR_CTRL_AUTO];
                    end
                end
                SLHR_STOP:
                begin
                    if (wake)
                    begin
                        pstop_r <= 1'b0;
                        if (ctrl_r[`SLHR_CTRL_NOLH])
                            state_r <= SLHR_RUN;
                        else
                        begin
                            vco_restart <= pstop_r & (ctrl_r[`SLHR_CTRL_DLY] | !mon_ok);
                            if (ctrl_r[`SLHR_CTRL_DLY])
                                state_r <= SLHR_DELAY;
                            else if (mon_ok)
                                state_r <= SLHR_RUN;
                            else
                            begin
                                state_r  <= SLHR_LIMP;
                                active_r <= 1'b1;
                            end
                        end
                    end
                end
                SLHR_DELAY:
                begin
                    if (mid_hit)
                    begin
                        if (mon_ok)
                            state_r <= SLHR_RUN;
                        else
                        begin
                            state_r  <= SLHR_LIMP;
                            active_r <= 1'b1;
                        end
                    end
                end
                SLHR_LIMP:
                begin
                    if (mid_hit && mon_ok)
                    begin
                        state_r  <= SLHR_RUN;
                        active_r <= 1'b0;
                        clksel_r <= {saved_sel_r[1], saved_sel_r[0] & clksel_r[0]};
                        pll_ramp_request <= saved_auto_r & saved_sel_r[0] & clksel_r[0];
                    end
                end
                default: state_r <= SLHR_RUN;
            endcase
        end
    end

    // Change flag: a set beats a software clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            change_r <= 1'b0;
        else if (aclken)
        begin
            if ((state_r == SLHR_DELAY && mid_hit && !mon_ok) ||
                (state_r == SLHR_STOP && wake && !ctrl_r[`SLHR_CTRL_NOLH] && !ctrl_r[`SLHR_CTRL_DLY] && !mon_ok) ||
                (state_r == SLHR_LIMP && mid_hit && mon_ok))
                change_r <= 1'b1;
            else if (change_clr)
                change_r <= 1'b0;
        end
    end

    // Registered clock-control outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stop_active          <= 1'b0;
            pseudo_stop_active   <= 1'b0;
            limp_home_mode       <= 1'b0;
            clock_monitor_force  <= 1'b0;
            clock_monitor_enable <= 1'b0;
            bus_clock_pll_select <= 1'b0;
            module_clock_select  <= 1'b0;
            limp_home_irq        <= 1'b0;
        end
        else if (aclken)
        begin
            stop_active        <= state_r == SLHR_STOP || state_r == SLHR_DELAY;
            pseudo_stop_active <= pstop_r;
            limp_home_mode     <= state_r == SLHR_DELAY || state_r == SLHR_LIMP;
            clock_monitor_force <= state_r == SLHR_DELAY || state_r == SLHR_LIMP;
            clock_monitor_enable <= (state_r == SLHR_STOP) ? 1'b0 :
                                    (state_r != SLHR_RUN) | ctrl_r[`SLHR_CTRL_CME] | ctrl_r[`SLHR_CTRL_FORCED_CLOCK_MONITOR_ENABLE];
            if (state_r == SLHR_DELAY || state_r == SLHR_LIMP)
            begin
                bus_clock_pll_select <= 1'b1;
                module_clock_select  <= 1'b0;
            end
            else
            begin
                bus_clock_pll_select <= clksel_r[`SLHR_SEL_BUS_CLOCK_PLL_SELECT];
                module_clock_select  <= clksel_r[`SLHR_SEL_MCS];
            end
            limp_home_irq <= change_r & ctrl_r[`SLHR_CTRL_IRQE];
        end
    end

    slhr_counter u_counter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .aclken  (aclken),
        .tick    (cnt_tick),
        .clear   (cnt_clear),
        .count   (count),
        .mid_hit (mid_hit)
    );
endmodule : slhr_stop_exit

// ---- slhr_defines.svh ----
// Overview of operation
// - With limp-home enabled, STOP entry masks both clock-monitor enables.
// - Leaving STOP with limp-home enabled enters limp-home with monitor forced on, unless delay is off and the monitor sees a good clock.
// - Exit delay on: count 4096 on floor VCO, then check monitor, resume on oscillator.
// - No clock after 4096 count: resume in limp-home, set active and change flags.
// - In limp-home, sample monitor at each mid-count 4096, every 8192 cycles.
// - Clock found in limp-home: leave, clear active flag, set change flag.
// - Delay off with crystal: release STOP at once, run in limp-home meanwhile.
// - Leaving limp-home restores bus-clock PLL select and module clock select.
// - Auto bandwidth plus PLL select saved: request PLL ramp after limp-home.
// - Square-wave clock present, delay off: release at once, active flag stays clear.
// - Pseudo-STOP select set makes STOP enter pseudo-STOP, oscillator kept running.
// - Reset, either interrupt pin, key wake-up or CAN wake-up ends STOP.
// - Pseudo-STOP exit with delay enters limp-home, forcing PLL select high, module low.
// - Crystal failed in pseudo-STOP: resume on floor VCO with both flags set.
// - Pseudo-STOP exit with delay cleared releases immediately like fast recovery.
// - Pseudo-STOP limp-home recovery restarts halted VCO, passed to core at once.
// - Delay bit gives 4096-count wait; cleared gives none; counter runs on slow clock.
// - In limp-home, module and bus clocks come from the floor-frequency PLL clock.
`ifndef SLHR_DEFINES_SVH
`define SLHR_DEFINES_SVH
`define SLHR_ADDR_CTRL      8'h00
`define SLHR_ADDR_STATUS    8'h04
`define SLHR_ADDR_CLKSEL    8'h08
`define SLHR_CTRL_NOLH      0
`define SLHR_CTRL_CME       1
`define SLHR_CTRL_FORCED_CLOCK_MONITOR_ENABLE      2
`define SLHR_CTRL_DLY       3
`define SLHR_CTRL_PSEUDO_STOP_SELECT      4
`define SLHR_CTRL_IRQE      5
`define SLHR_CTRL_AUTO      6
`define SLHR_CTRL_RESET     32'h0000_0002
`define SLHR_ST_ACTIVE      0
`define SLHR_ST_CHANGE      1
`define SLHR_ST_STOPPED     2
`define SLHR_ST_PSTOP       3
`define SLHR_ST_CMFAIL      4
`define SLHR_SEL_BUS_CLOCK_PLL_SELECT       0
`define SLHR_SEL_MCS        1
`define SLHR_CNT_W          13
`define SLHR_MID_COUNT      13'h1000
`define SLHR_RESP_OKAY      2'b00
`define SLHR_RESP_SLVERR    2'b10
`endif

// ---- slhr_pkg.sv ----
package slhr_pkg;
    typedef enum logic [2:0] {
        SLHR_RUN,
        SLHR_STOP,
        SLHR_DELAY,
        SLHR_LIMP
    } slhr_state_t;
    typedef logic [12:0] slhr_cnt_t;
endpackage : slhr_pkg

// ---- slhr_counter.sv ----
`timescale 1ns/1ps
`include "slhr_defines.svh"
module slhr_counter
    import slhr_pkg::*;
(
    // Clock and reset
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire logic      aclken,
    // Counter control
    input  wire logic      tick,
    input  wire logic      clear,
    // Counter state
    output slhr_cnt_t      count,
    output logic           mid_hit
);
    slhr_cnt_t count_r;

    // Free-running 13-stage counter; mid_hit marks the step onto 4096
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_r <= '0;
            mid_hit <= 1'b0;
        end
        else if (aclken)
        begin
            if (clear)
            begin
                count_r <= '0;
                mid_hit <= 1'b0;
            end
            else if (tick)
            begin
                count_r <= count_r + 13'h0001;
                mid_hit <= (count_r == 13'h0FFF);
            end
            else
            begin
                mid_hit <= 1'b0;
            end
        end
    end

    assign count = count_r;
endmodule : slhr_counter

// ---- slhr_chk_sva.sv ----
`timescale 1ns/1ps
module slhr_chk
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus answers
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Clock control
    input wire logic        limp_home_mode,
    input wire logic        clock_monitor_force,
    input wire logic        clock_monitor_ok,
    input wire logic        bus_clock_pll_select,
    input wire logic        module_clock_select,
    input wire logic        vco_restart,
    input wire logic        pll_ramp_request
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Settled limp-home keeps the monitor forced on
    limp_force_a: assert property (limp_home_mode && $past(limp_home_mode) |-> clock_monitor_force)
        else $error("monitor not forced during limp-home");
    limp_bus_a: assert property (limp_home_mode && $past(limp_home_mode) |-> bus_clock_pll_select)
        else $error("bus clock not on the pll during limp-home");
    limp_module_a: assert property (limp_home_mode && $past(limp_home_mode) |-> !module_clock_select)
        else $error("module clock select high during limp-home");
    vco_limp_a: assert property (vco_restart |-> ##[0:2] limp_home_mode)
        else $error("vco restarted without limp-home");
    ramp_after_a: assert property (pll_ramp_request |-> limp_home_mode ##1 !limp_home_mode)
        else $error("pll ramp not right after limp-home exit");
    // Exit only on a good clock seen through the two-flop sync
    limp_exit_a: assert property ($fell(limp_home_mode) |->
        $past(clock_monitor_ok, 3) || $past(clock_monitor_ok, 4) || $past(clock_monitor_ok, 5))
        else $error("limp-home left without a good clock");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule : slhr_chk

// ---- slhr_osc_model.sv ----
`timescale 1ns/1ps
module slhr_osc_model
#(
    parameter int STARTUP = 3
)
(
    // Clock and control
    input  wire logic aclk,
    input  wire logic running,
    // Monitor view
    output logic      clock_monitor_ok
);
    int ramp = 0;
    initial clock_monitor_ok = 1'b0;
    // A crystal needs some swing before the monitor trusts it
    always @(posedge aclk)
    begin
        ramp <= running ? ((ramp < STARTUP) ? ramp + 1 : ramp) : 0;
        clock_monitor_ok <= running && (ramp >= STARTUP);
    end
endmodule : slhr_osc_model

// ---- tb_stop_exit_limp_home_recovery.sv ----
`timescale 1ns/1ps
`include "slhr_defines.svh"
module tb_stop_exit_limp_home_recovery;
    localparam logic [7:0] A_CTL = `SLHR_ADDR_CTRL;
    localparam logic [7:0] A_ST  = `SLHR_ADDR_STATUS;
    localparam logic [7:0] A_SEL = `SLHR_ADDR_CLKSEL;
    localparam logic [1:0] OK    = `SLHR_RESP_OKAY;
    localparam logic [1:0] ERR   = `SLHR_RESP_SLVERR;
    logic        aclk, aresetn, aclken, stop_instr, slow_divided_clock_tick, osc_on, vco_seen, ramp_seen;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic [5:0]  wk;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_monitor_ok;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         stop_active, pseudo_stop_active, limp_home_mode, clock_monitor_force, clock_monitor_enable;
    wire         bus_clock_pll_select, module_clock_select, vco_restart, pll_ramp_request;
    wire         clock_monitor_reset, limp_home_irq;
    int          fail_count, comparisons;

    slhr_stop_exit uut (.aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .stop_instr, .slow_divided_clock_tick, .ext_reset_pin(wk[5]),
        .irq_pin_n(!wk[0]), .nonmaskable_interrupt_pin(wk[1]), .key_wake_j(wk[2]), .key_wake_h(wk[3]),
        .can_wake(wk[4]), .clock_monitor_ok, .stop_active, .pseudo_stop_active, .limp_home_mode,
        .clock_monitor_force, .clock_monitor_enable, .bus_clock_pll_select, .module_clock_select,
        .vco_restart, .pll_ramp_request, .clock_monitor_reset, .limp_home_irq);
    slhr_osc_model osc (.aclk, .running(osc_on), .clock_monitor_ok);

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Catch one-cycle pulses between checks
    always @(posedge aclk)
    begin
        if (vco_restart === 1'b1)
            vco_seen <= 1'b1;
        if (pll_ramp_request === 1'b1)
            ramp_seen <= 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic chk1(input logic s, input logic e);
        check({31'h0, s}, {31'h0, e});
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (s_axi_bvalid !== 1'b1)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        // Late ready stalls the response once so its hold is exercised
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (s_axi_rvalid !== 1'b1)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        check(s_axi_rdata, e);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd_chk
    function automatic logic pick(input int sel);
        return (sel == 0) ? stop_active : limp_home_mode;
    endfunction : pick
    task automatic wait_lvl(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (pick(sel) !== v && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_lvl
    task automatic do_stop;
        stop_instr <= 1'b1;
        @(posedge aclk);
        stop_instr <= 1'b0;
        cyc(4);
    endtask : do_stop
    task automatic wake(input int i);
        wk <= 6'h01 << i;
        cyc(4);
        wk <= 6'h00;
    endtask : wake
    task automatic wrap_up;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial
    begin
        #4000000;
        fail_count++;
        wrap_up;
    end

    initial
    begin
        int n;
        {aresetn, stop_instr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wk, vco_seen, ramp_seen} = '0;
        {aclken, slow_divided_clock_tick, osc_on} = 3'b111;
        s_axi_wstrb = 4'hF;
        cyc(5);
        aresetn <= 1'b1;
        cyc(2);
        rd_chk(A_CTL, 32'h0000_0002, OK);
        rd_chk(A_ST, 32'h0000_0000, OK);
        rd_chk(A_SEL, 32'h0000_0000, OK);
        rd_chk(8'h0C, 32'h0000_0000, ERR);
        wr(8'h0C, 32'hFFFF_FFFF, ERR);
        wr(A_ST, 32'h0000_001D, OK);
        rd_chk(A_ST, 32'h0000_0000, OK);
        $display("registers finished");
        // Fast recovery on a square-wave clock, every wake source
        for (int i = 0; i < 6; i++)
        begin
            do_stop;
            chk1(stop_active, 1'b1);
            wake(i);
            wait_lvl(0, 1'b0, 20, n);
            chk1(n < 20, 1'b1);
            chk1(limp_home_mode, 1'b0);
        end
        rd_chk(A_ST, 32'h0000_0000, OK);
        $display("wake sources finished");
        // Pseudo-stop, no delay, crystal lost meanwhile
        osc_on <= 1'b0;
        wr(A_CTL, 32'h0000_0012, OK);
        do_stop;
        chk1(pseudo_stop_active, 1'b1);
        vco_seen <= 1'b0;
        wake(4);
        wait_lvl(0, 1'b0, 20, n);
        chk1(n < 20, 1'b1);
        chk1(limp_home_mode, 1'b1);
        chk1(vco_seen, 1'b1);
        osc_on <= 1'b1;
        wait_lvl(1, 1'b0, 8300, n);
        chk1(limp_home_mode, 1'b0);
        chk1(limp_home_irq, 1'b0);
        rd_chk(A_ST, 32'h0000_0002, OK);
        wr(A_ST, 32'h0000_0002, OK);
        // Pseudo-stop with delay, crystal kept running
        wr(A_CTL, 32'h0000_0018, OK);
        do_stop;
        wake(2);
        cyc(4);
        chk1(limp_home_mode, 1'b1);
        check({30'h0, bus_clock_pll_select, module_clock_select}, 32'h2);
        wait_lvl(0, 1'b0, 4200, n);
        chk1(limp_home_mode, 1'b0);
        rd_chk(A_ST, 32'h0000_0000, OK);
        $display("pseudo stop finished");
        // Delayed exit into limp-home, then the clock returns
        wr(A_SEL, 32'h0000_0003, OK);
        wr(A_CTL, 32'h0000_006A, OK);
        osc_on <= 1'b0;
        slow_divided_clock_tick <= 1'b0;
        do_stop;
        chk1(stop_active, 1'b1);
        chk1(clock_monitor_enable, 1'b0);
        wake(3);
        cyc(996);
        chk1(stop_active, 1'b1);
        slow_divided_clock_tick <= 1'b1;
        wait_lvl(0, 1'b0, 4300, n);
        chk1(n >= 4090 && n <= 4110, 1'b1);
        chk1(limp_home_mode, 1'b1);
        chk1(clock_monitor_force, 1'b1);
        check({30'h0, bus_clock_pll_select, module_clock_select}, 32'h2);
        rd_chk(A_ST, 32'h0000_0007, OK);
        chk1(limp_home_irq, 1'b1);
        wr(A_ST, 32'h0000_0002, OK);
        cyc(2);
        chk1(limp_home_irq, 1'b0);
        rd_chk(A_ST, 32'h0000_0005, OK);
        ramp_seen <= 1'b0;
        osc_on <= 1'b1;
        cyc(7900);
        chk1(limp_home_mode, 1'b1);
        wait_lvl(1, 1'b0, 400, n);
        cyc(3);
        chk1(limp_home_mode, 1'b0);
        chk1(limp_home_irq, 1'b1);
        check({30'h0, bus_clock_pll_select, module_clock_select}, 32'h3);
        chk1(ramp_seen, 1'b1);
        rd_chk(A_SEL, 32'h0000_0003, OK);
        rd_chk(A_ST, 32'h0000_0002, OK);
        $display("limp-home finished");
        wrap_up;
    end
endmodule : tb_stop_exit_limp_home_recovery

bind slhr_stop_exit slhr_chk chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .limp_home_mode, .clock_monitor_force,
    .clock_monitor_ok, .bus_clock_pll_select, .module_clock_select, .vco_restart, .pll_ramp_request);
